// file: rtl/idf_consts.svh
// Constants for the instruction decode front end: toy encoding and queue sizes.
// Assumes inclusion by idf_front_end only.
`ifndef IDF_CONSTS_SVH
`define IDF_CONSTS_SVH
`define IDF_BLK_BYTES 5'h10
`define IDF_LANES_N 4
`define IDF_LANES 4'h4
`define IDF_UOP_MAX 3'h4
`define IDF_DEC_MAX 4'h4
`define IDF_ROM_STEP 4'h4
`define IDF_INSTQ_N 8
`define IDF_INSTQ_ROOM 4'h4
`define IDF_RSB_N 8
`define IDF_DOQ_N 4
`define IDF_DOQ_DEPTH 3'h4
`define IDF_LEN_LSB 0
`define IDF_CLS_LSB 2
`define IDF_AUX_LSB 5
`define IDF_CC_LSB 8
`define IDF_BACK_BIT 15
`define IDF_U_MAC 15
`define IDF_U_MIC 14
`define IDF_U_CLS 11
`define IDF_U_CC 7
`define IDF_U_SEQ 3
`endif

// file: rtl/idf_front_end.sv
// Decode front end: fetch block, length decoder, per-thread instruction queues,
// four decode lanes, microcode sequencer, return stack, decoded-op queue with loop replay.
// Assumes aligned blocks and that no instruction straddles a block.
`timescale 1ns/1ps
`include "idf_consts.svh"
module idf_front_end (
   input logic clk_i,
   input logic rst_b_i,
   input logic ic_valid_i,
   output logic ic_ready_o,
   input logic ic_tid_i,
   input logic [31:0] ic_addr_i,
   input logic [127:0] ic_data_i,
   input logic [1:0] thr_act_i,
   input logic mode64_i,
   input logic flush_i,
   input logic flush_tid_i,
   input logic [2:0] flush_tos_i,
   output logic out_valid_o,
   input logic out_ready_i,
   output logic out_tid_o,
   output logic [2:0] out_cnt_o,
   output logic [63:0] out_uops_o,
   output logic [31:0] out_addr_o,
   output logic [31:0] out_tgt_o,
   output logic [2:0] out_tos_o,
   output logic out_m64_o,
   output logic out_replay_o
);
   function automatic idf_pkg::idf_cls_t cls_of(input logic [31:0] e);
      return idf_pkg::idf_cls_t'(e[`IDF_CLS_LSB +: 3]);
   endfunction : cls_of

   function automatic logic [15:0] make_uop(input idf_pkg::idf_cls_t c, input logic [3:0] cc,
         input logic [3:0] seq, input logic mac, input logic mic);
      logic [15:0] u;
      u = 16'h0000;
      u[`IDF_U_MAC] = mac;
      u[`IDF_U_MIC] = mic;
      u[`IDF_U_CLS +: 3] = c;
      u[`IDF_U_CC +: 4] = cc;
      u[`IDF_U_SEQ +: 4] = seq;
      return u;
   endfunction : make_uop

   // Sequencer table; each step is its own uop so allocation sees the index
   function automatic logic [15:0] microcode_rom(input logic [3:0] idx);
      return make_uop(idf_pkg::CLS_CPLX, 4'h0, idx, 1'b0, 1'b0);
   endfunction : microcode_rom

   // Operand form is not consulted: all four forms fuse alike
   function automatic logic fusable(input logic [31:0] a, input logic [31:0] b);
      logic [3:0] cc;
      logic ok;
      cc = b[`IDF_CC_LSB +: 4];
      ok = 1'b0;
      if (cls_of(b) == idf_pkg::CLS_JCC) begin
         case (cls_of(a))
            idf_pkg::CLS_TEST: ok = 1'b1;
            idf_pkg::CLS_COMPARE_OP: begin
               ok = cc inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
               ok = ok || (cc inside {4'hc, 4'hd, 4'he, 4'hf});
            end
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction : fusable

   logic blk_v_q, blk_v_d, blk_tid_q, blk_tid_d;
   logic [31:0] blk_addr_q, blk_addr_d;
   logic [127:0] blk_q, blk_d;
   logic [4:0] blk_off_q, blk_off_d;
   logic [63:0] instq_q [2][`IDF_INSTQ_N];
   logic [63:0] instq_d [2][`IDF_INSTQ_N];
   logic [2:0] instq_rd_q [2];
   logic [2:0] instq_rd_d [2];
   logic [2:0] instq_wr_q [2];
   logic [2:0] instq_wr_d [2];
   logic [3:0] instq_cnt_q [2];
   logic [3:0] instq_cnt_d [2];
   logic [31:0] rsb_q [2][`IDF_RSB_N];
   logic [31:0] rsb_d [2][`IDF_RSB_N];
   logic [2:0] tos_q [2];
   logic [2:0] tos_d [2];
   logic sel_q, sel_d;
   logic rom_v_q, rom_v_d, rom_tid_q, rom_tid_d;
   logic [3:0] rom_idx_q, rom_idx_d, rom_n_q, rom_n_d;
   logic [31:0] rom_addr_q, rom_addr_d;
   idf_pkg::idf_grp_t doq_q [`IDF_DOQ_N];
   idf_pkg::idf_grp_t doq_d [`IDF_DOQ_N];
   logic [1:0] doq_rd_q, doq_rd_d, doq_wr_q, doq_wr_d;
   logic [2:0] doq_cnt_q, doq_cnt_d;
   idf_pkg::idf_lsd_t lsd_q, lsd_d;
   logic [31:0] lsd_addr_q, lsd_addr_d;
   idf_pkg::idf_grp_t lsd_grp_q, lsd_grp_d, grp, head;
   logic [159:0] sh;
   logic [31:0] ins, e, nx;
   logic [63:0] win [`IDF_LANES_N];
   logic [4:0] p;
   logic [2:0] npush, nu, elen;
   logic [3:0] pos, n;
   logic ld_ok, dec_ok, stop, sel, both, pop, push, rom_go, bk, replay;
   idf_pkg::idf_cls_t c;

   assign head = replay ? lsd_grp_q : doq_q[doq_rd_q];
   assign out_tid_o = head.tid;
   assign out_cnt_o = head.cnt;
   assign out_uops_o = head.uops;
   assign out_addr_o = head.addr;
   assign out_tgt_o = head.tgt;
   assign out_tos_o = head.tos;
   assign out_m64_o = head.m64;
   assign out_replay_o = replay;

   always_comb begin
      blk_v_d = blk_v_q;
      blk_tid_d = blk_tid_q;
      blk_addr_d = blk_addr_q;
      blk_d = blk_q;
      blk_off_d = blk_off_q;
      instq_d = instq_q;
      instq_rd_d = instq_rd_q;
      instq_wr_d = instq_wr_q;
      instq_cnt_d = instq_cnt_q;
      rsb_d = rsb_q;
      tos_d = tos_q;
      rom_v_d = rom_v_q;
      rom_tid_d = rom_tid_q;
      rom_idx_d = rom_idx_q;
      rom_n_d = rom_n_q;
      rom_addr_d = rom_addr_q;
      doq_d = doq_q;
      lsd_d = lsd_q;
      lsd_addr_d = lsd_addr_q;
      lsd_grp_d = lsd_grp_q;
      // Fetch: a whole block or nothing; stalls while a loop replays
      ic_ready_o = !blk_v_q && (lsd_q != idf_pkg::LSD_LOCK);
      if (ic_valid_i && ic_ready_o) begin
         blk_v_d = 1'b1;
         blk_tid_d = ic_tid_i;
         blk_addr_d = ic_addr_i;
         blk_d = ic_data_i;
         blk_off_d = '0;
      end
      // Length decoder: up to four starts per cycle, only with room for four
      p = blk_off_q;
      npush = 3'h0;
      ld_ok = blk_v_q && (instq_cnt_q[blk_tid_q] <= `IDF_INSTQ_ROOM)
            && (lsd_q != idf_pkg::LSD_LOCK);
      for (int k = 0; k < `IDF_LANES_N; k++) begin
         sh = {32'h0000_0000, blk_q} >> {p, 3'h0};
         ins = sh[31:0];
         len_calc: begin
            elen = {1'b0, ins[`IDF_LEN_LSB +: 2]} + 3'h1;
         end
         if (ld_ok && (p < `IDF_BLK_BYTES)) begin
            instq_d[blk_tid_q][3'(instq_wr_q[blk_tid_q] + npush)] = {blk_addr_q + 32'(p), ins};
            npush = npush + 3'h1;
            p = p + 5'(elen);
         end
      end
      if (ld_ok) begin
         blk_off_d = p;
         if (p >= `IDF_BLK_BYTES) begin
            blk_v_d = 1'b0;
         end
      end
      // Thread pick: strict alternation even if one side is empty
      both = &thr_act_i;
      sel = both ? sel_q : (thr_act_i[1] & ~thr_act_i[0]);
      sel_d = both ? ~sel_q : sel;
      for (int i = 0; i < `IDF_LANES_N; i++) begin
         win[i] = instq_q[sel][3'(instq_rd_q[sel] + 3'(i))];
      end
      grp = '0;
      grp.tid = sel;
      grp.m64 = mode64_i;
      grp.addr = win[0][63:32];
      pos = 4'h0;
      nu = 3'h0;
      stop = 1'b0;
      bk = 1'b0;
      rom_go = 1'b0;
      dec_ok = !rom_v_q && (lsd_q != idf_pkg::LSD_LOCK) && (doq_cnt_q < `IDF_DOQ_DEPTH);
      for (int l = 0; l < `IDF_LANES_N; l++) begin
         e = win[pos[1:0]][31:0];
         nx = win[2'(pos[1:0] + 2'h1)][31:0];
         c = cls_of(e);
         n = {1'b0, e[`IDF_AUX_LSB +: 3]} + 4'h1;
         elen = {1'b0, e[`IDF_LEN_LSB +: 2]} + 3'h1;
         if (dec_ok && !stop && (pos < instq_cnt_q[sel]) && (nu < `IDF_UOP_MAX)) begin
            if (c == idf_pkg::CLS_CPLX) begin
               if (l != 0) begin
                  stop = 1'b1;
               end else if (n > `IDF_DEC_MAX) begin
                  rom_go = 1'b1;
                  rom_n_d = n;
                  rom_idx_d = 4'h0;
                  rom_tid_d = sel;
                  rom_addr_d = win[0][63:32];
                  pos = pos + 4'h1;
                  stop = 1'b1;
               end else begin
                  for (int j = 0; j < `IDF_LANES_N; j++) begin
                     if (4'(j) < n) begin
                        grp.uops[16*j +: 16] = make_uop(c, 4'h0, 4'(j), 1'b0, 1'b0);
                     end
                  end
                  nu = n[2:0];
                  pos = pos + 4'h1;
               end
            end else if ((pos + 4'h1 < instq_cnt_q[sel]) && (pos + 4'h2 <= `IDF_LANES)
                  && fusable(e, nx)) begin
               // Fusion ignores mode64_i on purpose
               grp.uops[{nu[1:0], 4'h0} +: 16] = make_uop(idf_pkg::CLS_JCC,
                     nx[`IDF_CC_LSB +: 4], 4'h0, 1'b1, 1'b0);
               nu = nu + 3'h1;
               pos = pos + 4'h2;
               bk = nx[`IDF_BACK_BIT];
               stop = 1'b1;
            end else begin
               grp.uops[{nu[1:0], 4'h0} +: 16] = make_uop(c, e[`IDF_CC_LSB +: 4], 4'h0, 1'b0,
                     c == idf_pkg::CLS_ALU_MEM);
               nu = nu + 3'h1;
               pos = pos + 4'h1;
               if (c == idf_pkg::CLS_CALL) begin
                  tos_d[sel] = tos_d[sel] + 3'h1;
                  rsb_d[sel][tos_d[sel]] = win[pos[1:0] - 2'h1][63:32] + 32'(elen);
                  grp.tgt = rsb_d[sel][tos_d[sel]];
                  stop = 1'b1;
               end else if (c == idf_pkg::CLS_RET) begin
                  grp.tgt = rsb_q[sel][tos_d[sel]];
                  tos_d[sel] = tos_d[sel] - 3'h1;
                  stop = 1'b1;
               end else if (c == idf_pkg::CLS_JCC) begin
                  bk = e[`IDF_BACK_BIT];
                  stop = 1'b1;
               end
            end
         end
      end
      grp.tos = tos_d[sel];
      // Long sequences: the lanes sit idle while the ROM streams
      if (rom_v_q && (doq_cnt_q < `IDF_DOQ_DEPTH)) begin
         grp.tid = rom_tid_q;
         grp.addr = rom_addr_q;
         grp.tos = tos_q[rom_tid_q];
         for (int j = 0; j < `IDF_LANES_N; j++) begin
            if (rom_idx_q + 4'(j) < rom_n_q) begin
               grp.uops[16*j +: 16] = microcode_rom(rom_idx_q + 4'(j));
               nu = nu + 3'h1;
            end
         end
         rom_idx_d = rom_idx_q + `IDF_ROM_STEP;
         if (rom_idx_d >= rom_n_q) begin
            rom_v_d = 1'b0;
         end
      end
      if (rom_go) begin
         rom_v_d = 1'b1;
      end
      grp.cnt = nu;
      grp.live = !(flush_i && (flush_tid_i == grp.tid));
      push = (nu != 3'h0);
      for (int t = 0; t < 2; t++) begin
         instq_rd_d[t] = instq_rd_q[t] + ((sel == 1'(t)) ? pos[2:0] : 3'h0);
         instq_wr_d[t] = instq_wr_q[t] + ((ld_ok && (blk_tid_q == 1'(t))) ? npush : 3'h0);
         instq_cnt_d[t] = instq_cnt_q[t] - ((sel == 1'(t)) ? pos : 4'h0)
               + ((ld_ok && (blk_tid_q == 1'(t))) ? {1'b0, npush} : 4'h0);
      end
      // Decoded-op queue; dead heads leave silently
      replay = (lsd_q == idf_pkg::LSD_LOCK) && (doq_cnt_q == 3'h0);
      out_valid_o = replay || ((doq_cnt_q != 3'h0) && doq_q[doq_rd_q].live);
      pop = (doq_cnt_q != 3'h0) && (!doq_q[doq_rd_q].live || out_ready_i);
      if (push) begin
         doq_d[doq_wr_q] = grp;
      end
      doq_wr_d = doq_wr_q + {1'b0, push};
      doq_rd_d = doq_rd_q + {1'b0, pop};
      doq_cnt_d = doq_cnt_q + {2'h0, push} - {2'h0, pop};
      // Loop detector: a one-group loop seen twice in a row locks replay
      unique case (lsd_q)
         idf_pkg::LSD_IDLE: begin
            if (push && bk) begin
               lsd_d = idf_pkg::LSD_ARM;
               lsd_addr_d = grp.addr;
            end
         end
         idf_pkg::LSD_ARM: begin
            if (push && bk && (grp.addr == lsd_addr_q)) begin
               lsd_d = idf_pkg::LSD_LOCK;
               lsd_grp_d = grp;
            end else if (push && bk) begin
               lsd_addr_d = grp.addr;
            end else if (push) begin
               lsd_d = idf_pkg::LSD_IDLE;
            end
         end
         idf_pkg::LSD_LOCK: lsd_d = idf_pkg::LSD_LOCK;
         default: lsd_d = idf_pkg::LSD_IDLE;
      endcase
      // Redirect: kill the thread's own state plus the shared loop detector, nothing waits on reclaim
      if (flush_i || both) begin
         lsd_d = idf_pkg::LSD_IDLE;
      end
      if (flush_i) begin
         instq_cnt_d[flush_tid_i] = 4'h0;
         instq_rd_d[flush_tid_i] = instq_wr_q[flush_tid_i];
         instq_wr_d[flush_tid_i] = instq_wr_q[flush_tid_i];
         if (blk_v_q && (blk_tid_q == flush_tid_i)) begin
            blk_v_d = 1'b0;
         end
         if (rom_tid_d == flush_tid_i) begin
            rom_v_d = 1'b0;
         end
         tos_d[flush_tid_i] = flush_tos_i;
         for (int i = 0; i < `IDF_DOQ_N; i++) begin
            if (doq_d[i].tid == flush_tid_i) begin
               doq_d[i].live = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         blk_v_q <= 1'b0;
         blk_tid_q <= 1'b0;
         blk_off_q <= '0;
         instq_rd_q <= '{default: '0};
         instq_wr_q <= '{default: '0};
         instq_cnt_q <= '{default: '0};
         tos_q <= '{default: '0};
         sel_q <= 1'b0;
         rom_v_q <= 1'b0;
         rom_tid_q <= 1'b0;
         rom_idx_q <= '0;
         rom_n_q <= '0;
         doq_q <= '{default: '0};
         doq_rd_q <= '0;
         doq_wr_q <= '0;
         doq_cnt_q <= '0;
         lsd_q <= idf_pkg::LSD_IDLE;
         lsd_grp_q <= '0;
      end else begin
         blk_v_q <= blk_v_d;
         blk_tid_q <= blk_tid_d;
         blk_off_q <= blk_off_d;
         instq_rd_q <= instq_rd_d;
         instq_wr_q <= instq_wr_d;
         instq_cnt_q <= instq_cnt_d;
         tos_q <= tos_d;
         sel_q <= sel_d;
         rom_v_q <= rom_v_d;
         rom_tid_q <= rom_tid_d;
         rom_idx_q <= rom_idx_d;
         rom_n_q <= rom_n_d;
         doq_q <= doq_d;
         doq_rd_q <= doq_rd_d;
         doq_wr_q <= doq_wr_d;
         doq_cnt_q <= doq_cnt_d;
         lsd_q <= lsd_d;
         lsd_grp_q <= lsd_grp_d;
      end
   end

   // Payload storage needs no reset: counts or valid flags gate every read except the return stack's
   always_ff @(posedge clk_i) begin
      blk_addr_q <= blk_addr_d;
      blk_q <= blk_d;
      instq_q <= instq_d;
      rsb_q <= rsb_d;
      rom_addr_q <= rom_addr_d;
      lsd_addr_q <= lsd_addr_d;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_fetch_take;
      ic_valid_i && ic_ready_o && !flush_i |=> blk_v_q && (blk_off_q == '0);
   endproperty
   a_fetch_take: assert property (p_fetch_take)
      else $error("fetched block not held");

   property p_instq_four;
      (pos <= `IDF_LANES) && (pos <= instq_cnt_q[sel]);
   endproperty
   a_instq_four: assert property (p_instq_four)
      else $error("more than four instructions taken");

   property p_cplx_lane0;
      push && !rom_v_q && (grp.uops[16 + `IDF_U_CLS +: 3] == idf_pkg::CLS_CPLX)
         |-> grp.uops[`IDF_U_CLS +: 3] == idf_pkg::CLS_CPLX;
   endproperty
   a_cplx_lane0: assert property (p_cplx_lane0)
      else $error("complex uop outside lane zero");

   property p_rom_start;
      rom_go && !flush_i |=> rom_v_q && (rom_idx_q == 4'h0) ##1 (pos == 4'h0);
   endproperty
   a_rom_start: assert property (p_rom_start)
      else $error("long instruction not sequenced by ROM");

   property p_four_uops;
      push |-> (grp.cnt <= `IDF_UOP_MAX) && (doq_cnt_q < `IDF_DOQ_DEPTH);
   endproperty
   a_four_uops: assert property (p_four_uops)
      else $error("too many uops in one cycle");

   property p_alternate;
      both |=> (sel_q != $past(sel_q));
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("threads did not alternate");

   property p_lsd_bypass;
      (lsd_q == idf_pkg::LSD_LOCK) |-> !ic_ready_o && (pos == 4'h0) && !ld_ok;
   endproperty
   a_lsd_bypass: assert property (p_lsd_bypass)
      else $error("fetch or decode active during replay");

   property p_tos_restore;
      flush_i |=> tos_q[$past(flush_tid_i)] == $past(flush_tos_i);
   endproperty
   a_tos_restore: assert property (p_tos_restore)
      else $error("return stack pointer not restored");

   property p_resume;
      flush_i && blk_v_q && (blk_tid_q == flush_tid_i) |=> ic_ready_o;
   endproperty
   a_resume: assert property (p_resume)
      else $error("fetch not ready after redirect");
endmodule : idf_front_end

// file: rtl/idf_pkg.sv
// Types shared by the decode front end.
// Assumes field positions come from idf_consts.svh.
package idf_pkg;
   typedef enum logic [2:0] {
      CLS_ALU = 3'h0,
      CLS_ALU_MEM = 3'h1,
      CLS_COMPARE_OP = 3'h2,
      CLS_TEST = 3'h3,
      CLS_JCC = 3'h4,
      CLS_CPLX = 3'h5,
      CLS_CALL = 3'h6,
      CLS_RET = 3'h7
   } idf_cls_t;
   typedef enum logic [1:0] {
      LSD_IDLE = 2'b00,
      LSD_ARM = 2'b01,
      LSD_LOCK = 2'b10
   } idf_lsd_t;
   typedef struct packed {
      logic live;
      logic tid;
      logic m64;
      logic [2:0] cnt;
      logic [2:0] tos;
      logic [31:0] addr;
      logic [31:0] tgt;
      logic [63:0] uops;
   } idf_grp_t;
endpackage : idf_pkg

// file: testbench/idf_cache_model.sv
// Instruction cache stand-in: offers queued aligned 16-byte blocks to fetch.
// Assumes the bench pushes blocks only after reset has been released.
`timescale 1ns/1ps
module idf_cache_model (
   input wire logic clk_i,
   input wire logic blk_ready_i,
   output logic blk_valid_o,
   output logic blk_tid_o,
   output logic [31:0] blk_addr_o,
   output logic [127:0] blk_data_o
);
   logic [160:0] q[$];
   logic take;
   task automatic push(input logic t, input logic [31:0] a, input logic [127:0] d);
      q.push_back({t, a, d});
   endtask : push
   initial begin
      blk_valid_o = 1'b0;
      {blk_tid_o, blk_addr_o, blk_data_o} = '0;
   end
   always @(posedge clk_i) begin
      take = blk_valid_o && blk_ready_i;
      #2;
      if (take) begin
         void'(q.pop_front());
      end
      if (take || !blk_valid_o) begin
         if (q.size() > 0) begin
            {blk_tid_o, blk_addr_o, blk_data_o} = q[0];
            blk_valid_o = 1'b1;
         end else begin
            // Idle lines toggle so stale bytes never pass for a block
            blk_valid_o = 1'b0;
            blk_data_o = ~blk_data_o;
            blk_addr_o = ~blk_addr_o;
         end
      end
   end
endmodule : idf_cache_model

// file: testbench/testbench.sv
// Self-checking bench: fusion table, complex and micro-fused blocks, threads, flush, loop.
// Assumes idf_cache_model feeds fetch; the bench plays the allocation stage.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((ex) !== (got)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module testbench;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ic_valid_i, ic_ready_o, ic_tid_i;
   logic [31:0] ic_addr_i, out_addr_o, out_tgt_o;
   logic [31:0] seed = 32'h0000_811c;
   logic [127:0] ic_data_i;
   logic [1:0] thr_act_i = 2'h1;
   logic mode64_i = 1'b0, flush_i = 1'b0, flush_tid_i = 1'b0, out_ready_i = 1'b1;
   logic [2:0] flush_tos_i = 3'h0, out_cnt_o, out_tos_o, fcnt, htos;
   logic out_valid_o, out_tid_o, out_m64_o, out_replay_o, fmac, ltid;
   logic stall = 1'b0, kill = 1'b0;
   logic [63:0] out_uops_o;
   logic [31:0] watch = 32'h0, old = 32'h0, ftgt, stgt;
   int errors = 0, checked = 0, cyc = 0, grp, sum, mic, cmax, b2b, stale, acc, hit, last;
   always #12.5 clk_i = ~clk_i;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction : xs
   function automatic logic fuses(input logic [2:0] c, input logic [3:0] cc);
      return (c == 3'h3) || ((c == 3'h2) && (cc inside {[4'h2:4'h7], [4'hc:4'hf]}));
   endfunction : fuses
   idf_cache_model m_cache (.clk_i(clk_i), .blk_ready_i(ic_ready_o), .blk_valid_o(ic_valid_i),
      .blk_tid_o(ic_tid_i), .blk_addr_o(ic_addr_i), .blk_data_o(ic_data_i));
   idf_front_end dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ic_valid_i(ic_valid_i),
      .ic_ready_o(ic_ready_o), .ic_tid_i(ic_tid_i), .ic_addr_i(ic_addr_i),
      .ic_data_i(ic_data_i), .thr_act_i(thr_act_i), .mode64_i(mode64_i), .flush_i(flush_i),
      .flush_tid_i(flush_tid_i), .flush_tos_i(flush_tos_i), .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i), .out_tid_o(out_tid_o), .out_cnt_o(out_cnt_o),
      .out_uops_o(out_uops_o), .out_addr_o(out_addr_o), .out_tgt_o(out_tgt_o),
      .out_tos_o(out_tos_o), .out_m64_o(out_m64_o), .out_replay_o(out_replay_o));
   always @(posedge clk_i) begin
      cyc++;
      if (rst_b_i && ic_valid_i && ic_ready_o && ic_addr_i === watch) acc = cyc;
      if (rst_b_i && out_valid_o && out_ready_i) begin
         if (grp == 0) begin
            fcnt = out_cnt_o;
            fmac = out_uops_o[15];
            ftgt = out_tgt_o;
         end
         if (grp == 1) stgt = out_tgt_o;
         grp++;
         sum += out_cnt_o;
         if (out_cnt_o > cmax) cmax = out_cnt_o;
         for (int k = 0; k < 4; k++) begin
            if (k < out_cnt_o) mic += out_uops_o[16*k+14];
         end
         if (thr_act_i == 2'h3 && last == cyc - 1 && ltid === out_tid_o) b2b++;
         last = cyc;
         ltid = out_tid_o;
         if (kill && out_addr_o[31:4] === old[31:4]) stale++;
         if (out_addr_o === watch && hit < 0) begin
            hit = cyc;
            htos = out_tos_o;
         end
         `CHK("group mode", mode64_i, out_m64_o)
      end
      #2;
      seed = xs(seed);
      out_ready_i = stall ? (seed[0] | seed[1]) : 1'b1;
   end
   task automatic clear();
      grp = 0;
      sum = 0;
      mic = 0;
      cmax = 0;
      b2b = 0;
      stale = 0;
      hit = -1;
      last = -9;
   endtask : clear
   task automatic settle();
      int quiet;
      quiet = 0;
      for (int i = 0; i < 400 && quiet < 12; i++) begin
         @(posedge clk_i);
         quiet = (m_cache.q.size() == 0 && out_valid_o === 1'b0) ? quiet + 1 : 0;
      end
      #2;
   endtask : settle
   task automatic run_block(input logic [31:0] a, input logic [127:0] d, input logic [3:0] ec,
         input logic em, input int es, input int emic);
      clear();
      mode64_i = seed[7];
      m_cache.push(1'b0, a, d);
      settle();
      if (ec != 4'hf) begin
         `CHK("first count", ec[2:0], fcnt)
         `CHK("first fused", em, fmac)
      end
      `CHK("uop total", es, sum)
      `CHK("micro fused", emic, mic)
      `CHK("widest group", 1'b1, cmax <= 4)
   endtask : run_block
   task automatic print_verdict();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   initial begin
      // Roughly 72 blocks at under 60 cycles each, with ample margin
      repeat (20000) @(posedge clk_i);
      errors++;
      print_verdict();
   end
   initial begin
      logic [127:0] d;
      logic [2:0] cl;
      logic f;
      int n;
      clear();
      repeat (16) @(posedge clk_i);
      #2;
      rst_b_i = 1'b1;
      stall = 1'b1;
      for (int c = 0; c < 3; c++) begin
         for (int cc = 0; cc < 16; cc++) begin
            cl = (c == 0) ? 3'h0 : 3'(c + 1);
            f = fuses(cl, cc[3:0]);
            seed = xs(seed);
            d = '0;
            d[7:0] = {1'b0, seed[1:0], cl, 2'h0};
            d[15:8] = 8'h11;
            d[23:16] = {4'h0, cc[3:0]};
            run_block(32'h0000_1000 + 32'(cc * 16), d, f ? 4'h1 : 4'h2, f, f ? 14 : 15, 0);
         end
      end
      for (int u = 1; u <= 8; u++) begin
         d = '0;
         d[7:0] = {3'(u - 1), 3'h5, 2'h0};
         run_block(32'h0000_2000 + 32'(u * 16), d, 4'hf, 1'b0, u + 15, 0);
      end
      for (int b = 0; b < 8; b++) begin
         n = 0;
         for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            d[8*k+:8] = seed[0] ? 8'h04 : 8'h00;
            n += seed[0];
         end
         run_block(32'h0000_6000 + 32'(b * 16), d, 4'hf, 1'b0, 16, n);
      end
      // Call then return: both groups must carry the return address
      d = '0;
      d[15:0] = 16'h1c18;
      run_block(32'h0000_7200, d, 4'h1, 1'b0, 16, 0);
      `CHK("call target", 32'h0000_7201, ftgt)
      `CHK("return target", 32'h0000_7201, stgt)
      // Steady ready so queue backlog cannot mask the thread pattern
      stall = 1'b0;
      thr_act_i = 2'h3;
      clear();
      m_cache.push(1'b0, 32'h0000_7000, '0);
      m_cache.push(1'b1, 32'h0000_7100, '0);
      settle();
      `CHK("two thread total", 32, sum)
      `CHK("same thread twice", 0, b2b)
      thr_act_i = 2'h1;
      clear();
      old = 32'h0000_3000;
      watch = 32'h0000_3100;
      m_cache.push(1'b0, old, '0);
      repeat (3) @(posedge clk_i);
      #2;
      flush_i = 1'b1;
      flush_tos_i = seed[2:0];
      m_cache.push(1'b0, watch, '0);
      @(posedge clk_i);
      #2;
      flush_i = 1'b0;
      kill = 1'b1;
      settle();
      `CHK("resume delay", 1'b1, (hit - acc) inside {[3:4]})
      `CHK("stale groups", 0, stale)
      `CHK("restored stack", flush_tos_i, htos)
      kill = 1'b0;
      d = '0;
      d[7:0] = 8'h03;
      d[39:32] = 8'h03;
      d[71:64] = 8'h03;
      d[103:96] = 8'h13;
      d[111:104] = 8'h85;
      m_cache.push(1'b0, 32'h0000_4000, d);
      m_cache.push(1'b0, 32'h0000_4000, d);
      repeat (40) @(posedge clk_i);
      m_cache.push(1'b0, 32'h0000_5000, '0);
      repeat (8) begin
         @(posedge clk_i);
         `CHK("replay group", {4'hd, 3'h4, 32'h0000_4000},
            {out_valid_o, out_replay_o, ic_ready_o, 1'b1, out_cnt_o, out_addr_o})
      end
      #2;
      flush_i = 1'b1;
      @(posedge clk_i);
      #2;
      flush_i = 1'b0;
      clear();
      settle();
      `CHK("fetch after unlock", 16, sum)
      print_verdict();
   end
endmodule : testbench
